// File: verilog/timer_link_host.sv
// Host controller driving the timer unit's mode, start and stop registers
//
// Behaviour
// - Only even channels programmed as masters
// - Channel zero never programmed as slave
// - Slaves always numbered above their master
// - Slave never spans past another master
// - Group slaves share master's clock select
// - Group start bits issued in one write
// - Start whole group or master only
// - Group stop bits issued in one write
// - Linked groups avoid third/fourth prescaler outputs
// - Start word 16 bits, upper byte zero
// - Wait 4/2 operating clocks before start
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module timer_link_host
  import timer_link_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic devWrite,
  output logic [1:0] devRegSel,
  output logic [2:0] devChan,
  output logic [15:0] devWdata,
  input wire logic devAck,
  input wire logic [7:0] channelEnableStatus
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic ackMeta_reg, ackSync_reg;
  logic [7:0] enMeta_reg, enSync_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ackMeta_reg <= 1'b0;
      ackSync_reg <= 1'b0;
      enMeta_reg <= 8'h00;
      enSync_reg <= 8'h00;
    end else begin
      ackMeta_reg <= devAck;
      ackSync_reg <= ackMeta_reg;
      enMeta_reg <= channelEnableStatus;
      enSync_reg <= enMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Linkage checker
  // ----------------------------------------------------------------
  link_check_if lc ();
  link_checker u_checker (.lc(lc));

  logic [7:0] masters_reg, masters_next;
  logic [7:0] slaves_reg, slaves_next;
  logic [15:0] clkSel_reg, clkSel_next;
  logic [7:0] filterEn_reg, filterEn_next;
  logic [7:0] pinSrc_reg, pinSrc_next;
  logic [7:0] waitScale_reg, waitScale_next;
  logic refused_reg, refused_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;

  assign lc.masters = masters_reg;
  assign lc.slaves = slaves_reg;
  assign lc.clkSel = clkSel_reg;
  assign lc.reqMask = wb_dat_i[CMD_MASK_LSB +: 8];

  // ----------------------------------------------------------------
  // Wishbone slave and host registers
  // ----------------------------------------------------------------
  host_state_t state_reg, state_next;
  logic [10:0] waitCnt_reg, waitCnt_next;
  logic devWrite_reg, devWrite_next;
  logic [1:0] devRegSel_reg, devRegSel_next;
  logic [2:0] devChan_reg, devChan_next;
  logic [15:0] devWdata_reg, devWdata_next;

  logic access, wrStrobe, cmdWrite, cmdOk, cmdGo;
  logic [1:0] cmdOp;
  logic [7:0] cmdMask;
  logic [2:0] cmdChan;
  logic [10:0] waitLoad;
  logic [15:0] modeWord;
  logic [31:0] readMux;

  assign access = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wrStrobe = access && wb_we_i;
  assign cmdWrite = wrStrobe && wb_adr_i[7:0] == ADDR_CMD;
  assign cmdOp = wb_dat_i[CMD_OP_LSB +: 2];
  assign cmdMask = wb_dat_i[CMD_MASK_LSB +: 8];
  assign cmdChan = wb_dat_i[CMD_MASK_LSB +: 3];

  always_comb begin
    cmdOk = 1'b0;
    case (cmdOp)
      OP_MODE: cmdOk = 1'b1;
      OP_START: cmdOk = lc.cfgErr == 4'h0 && !lc.startBad;
      OP_STOP: cmdOk = !lc.stopBad;
      default: cmdOk = 1'b0;
    endcase
  end

  assign cmdGo = cmdWrite && wb_sel_i[1:0] == 2'h3 && state_reg == S_IDLE && cmdOk;

  always_comb begin
    readMux = 32'h0000_0000;
    case (wb_adr_i[7:0])
      ADDR_MASTERS: readMux[7:0] = masters_reg;
      ADDR_SLAVES: readMux[7:0] = slaves_reg;
      ADDR_CLKSEL: readMux[15:0] = clkSel_reg;
      ADDR_FILTER: readMux[7:0] = filterEn_reg;
      ADDR_PINSRC: readMux[7:0] = pinSrc_reg;
      ADDR_WAITSCALE: readMux[7:0] = waitScale_reg;
      ADDR_STATUS: begin
        readMux[ST_BUSY] = state_reg != S_IDLE;
        readMux[ST_CFGERR] = lc.cfgErr != 4'h0;
        readMux[ST_REFUSED] = refused_reg;
        readMux[ST_WAITING] = waitCnt_reg != 11'h000;
        readMux[ST_ENABLE_LSB +: 8] = enSync_reg;
        readMux[ST_ERRDET_LSB +: 4] = lc.cfgErr;
      end
      default: readMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    masters_next = masters_reg;
    slaves_next = slaves_reg;
    clkSel_next = clkSel_reg;
    filterEn_next = filterEn_reg;
    pinSrc_next = pinSrc_reg;
    waitScale_next = waitScale_reg;
    refused_next = refused_reg;
    ack_next = access;
    rdata_next = access ? readMux : rdata_reg;
    if (wrStrobe && wb_sel_i[0]) begin
      case (wb_adr_i[7:0])
        ADDR_MASTERS: masters_next = wb_dat_i[7:0] | 8'h01;
        ADDR_SLAVES: slaves_next = wb_dat_i[7:0];
        ADDR_CLKSEL: clkSel_next[7:0] = wb_dat_i[7:0];
        ADDR_FILTER: filterEn_next = wb_dat_i[7:0];
        ADDR_PINSRC: pinSrc_next = wb_dat_i[7:0];
        ADDR_WAITSCALE: waitScale_next = wb_dat_i[7:0];
        ADDR_STATUS: refused_next = refused_reg && !wb_dat_i[ST_REFUSED];
        default: refused_next = refused_reg;
      endcase
    end
    if (wrStrobe && wb_sel_i[1] && wb_adr_i[7:0] == ADDR_CLKSEL) begin
      clkSel_next[15:8] = wb_dat_i[15:8];
    end
    // Set wins over a simultaneous clear
    if (cmdWrite && !cmdGo) begin
      refused_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      masters_reg <= RST_MASTERS;
      slaves_reg <= RST_SLAVES;
      clkSel_reg <= RST_CLKSEL;
      filterEn_reg <= RST_FILTER;
      pinSrc_reg <= RST_PINSRC;
      waitScale_reg <= RST_WAITSCALE;
      refused_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      masters_reg <= masters_next;
      slaves_reg <= slaves_next;
      clkSel_reg <= clkSel_next;
      filterEn_reg <= filterEn_next;
      pinSrc_reg <= pinSrc_next;
      waitScale_reg <= waitScale_next;
      refused_reg <= refused_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ----------------------------------------------------------------
  // Device write sequencer
  // ----------------------------------------------------------------
  always_comb begin
    modeWord = 16'h0000;
    modeWord[MODE_CKS_LSB +: 2] = clkSel_reg[2*cmdChan +: 2];
    modeWord[MODE_CCS_BIT] = pinSrc_reg[cmdChan];
    modeWord[MODE_MASTER_BIT] = masters_reg[cmdChan] && cmdChan != 3'h0 && !cmdChan[0];
  end

  assign waitLoad = 11'(filterEn_reg[devChan_reg] ? WAIT_FILTER_ON : WAIT_FILTER_OFF) * 11'(waitScale_reg);

  always_comb begin
    state_next = state_reg;
    waitCnt_next = (waitCnt_reg != 11'h000) ? waitCnt_reg - 11'h001 : waitCnt_reg;
    devWrite_next = devWrite_reg;
    devRegSel_next = devRegSel_reg;
    devChan_next = devChan_reg;
    devWdata_next = devWdata_reg;
    case (state_reg)
      S_IDLE: begin
        if (cmdGo) begin
          devRegSel_next = cmdOp;
          devChan_next = cmdChan;
          devWdata_next = (cmdOp == OP_MODE) ? modeWord : {8'h00, cmdMask};
          if (cmdOp == OP_START && waitCnt_reg > 11'h001) begin
            state_next = S_WAIT;
          end else begin
            state_next = S_WRITE;
            devWrite_next = 1'b1;
          end
        end
      end
      S_WAIT: begin
        if (waitCnt_reg <= 11'h001) begin
          state_next = S_WRITE;
          devWrite_next = 1'b1;
        end
      end
      S_WRITE: begin
        if (ackSync_reg) begin
          devWrite_next = 1'b0;
          state_next = S_DROP;
          if (devRegSel_reg == DEV_SEL_MODE && pinSrc_reg[devChan_reg]) begin
            waitCnt_next = waitLoad;
          end
        end
      end
      S_DROP: begin
        if (!ackSync_reg) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
        devWrite_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      waitCnt_reg <= RST_WAITCNT;
      devWrite_reg <= 1'b0;
      devRegSel_reg <= DEV_SEL_MODE;
      devChan_reg <= 3'h0;
      devWdata_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      waitCnt_reg <= waitCnt_next;
      devWrite_reg <= devWrite_next;
      devRegSel_reg <= devRegSel_next;
      devChan_reg <= devChan_next;
      devWdata_reg <= devWdata_next;
    end
  end

  assign devWrite = devWrite_reg;
  assign devRegSel = devRegSel_reg;
  assign devChan = devChan_reg;
  assign devWdata = devWdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic startPartial, stopPartial;
  always_comb begin
    startPartial = 1'b0;
    stopPartial = 1'b0;
    for (int k = 1; k < 8; k++) begin
      if (slaves_reg[k] && devWdata_reg[k] && !devWdata_reg[owner_of(masters_reg, k)]) begin
        startPartial = 1'b1;
      end
      if (slaves_reg[k] && devWdata_reg[k] != devWdata_reg[owner_of(masters_reg, k)]) begin
        stopPartial = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_upper_zero;
    devWrite && devRegSel == DEV_SEL_START |-> devWdata[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("start word upper byte not zero");

  property p_hold_write;
    devWrite && !ackSync_reg |=> devWrite && $stable(devWdata) && $stable(devRegSel) && $stable(devChan);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("device write changed before ack");

  property p_no_partial_start;
    $rose(devWrite) && devRegSel == DEV_SEL_START |-> !startPartial;
  endproperty
  a_no_partial_start: assert property (p_no_partial_start) else $error("slave started without its master");

  property p_whole_stop;
    $rose(devWrite) && devRegSel == DEV_SEL_STOP |-> !stopPartial;
  endproperty
  a_whole_stop: assert property (p_whole_stop) else $error("partial group stop issued");

  property p_start_settled;
    $rose(devWrite) && devRegSel == DEV_SEL_START |-> waitCnt_reg <= 11'h001;
  endproperty
  a_start_settled: assert property (p_start_settled) else $error("start issued before pin settling");

  property p_wait_load;
    state_reg == S_WRITE && ackSync_reg && devRegSel == DEV_SEL_MODE && pinSrc_reg[devChan]
      |=> waitCnt_reg == $past(waitLoad);
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("settling counter not loaded");

  property p_chan0_master;
    devWrite && devRegSel == DEV_SEL_MODE && devChan == 3'h0 |-> !devWdata[MODE_MASTER_BIT];
  endproperty
  a_chan0_master: assert property (p_chan0_master) else $error("channel zero master bit set");

  property p_even_master;
    devWrite && devRegSel == DEV_SEL_MODE && devChan[0] |-> !devWdata[MODE_MASTER_BIT];
  endproperty
  a_even_master: assert property (p_even_master) else $error("odd channel made master");

  property p_start_cks;
    $rose(devWrite) && devRegSel == DEV_SEL_START |-> !lc.cfgErr[2] && !lc.cfgErr[1];
  endproperty
  a_start_cks: assert property (p_start_cks) else $error("start with mismatched group clocks");

  property p_start_high_out;
    $rose(devWrite) && devRegSel == DEV_SEL_START |-> !lc.cfgErr[3];
  endproperty
  a_start_high_out: assert property (p_start_high_out) else $error("start with high prescaler output");

  property p_refuse;
    cmdWrite && !cmdGo |=> refused_reg && !($past(state_reg) == S_IDLE && state_reg != S_IDLE);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused command not flagged");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack longer than one cycle");

  c_start: cover property ($rose(devWrite) && devRegSel == DEV_SEL_START);
  c_stop: cover property ($rose(devWrite) && devRegSel == DEV_SEL_STOP);
  c_wait: cover property (state_reg == S_WAIT ##[1:100] state_reg == S_WRITE);
  c_refused: cover property ($rose(refused_reg));

endmodule : timer_link_host

// File: verilog/timer_link_pkg.sv
// Constants, types and helpers shared by the timer link host files
package timer_link_pkg;

  // ----------------------------------------------------------------
  // Host register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MASTERS = 8'h00;
  localparam logic [7:0] ADDR_SLAVES = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL = 8'h08;
  localparam logic [7:0] ADDR_FILTER = 8'h0c;
  localparam logic [7:0] ADDR_PINSRC = 8'h10;
  localparam logic [7:0] ADDR_WAITSCALE = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MASTERS = 8'h01;
  localparam logic [7:0] RST_SLAVES = 8'h00;
  localparam logic [15:0] RST_CLKSEL = 16'h0000;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] RST_PINSRC = 8'h00;
  localparam logic [7:0] RST_WAITSCALE = 8'h01;
  localparam logic [10:0] RST_WAITCNT = 11'h000;

  // ----------------------------------------------------------------
  // Command word fields and codes
  // ----------------------------------------------------------------
  localparam int CMD_MASK_LSB = 0;
  localparam int CMD_OP_LSB = 8;
  localparam logic [1:0] OP_MODE = 2'h0;
  localparam logic [1:0] OP_START = 2'h1;
  localparam logic [1:0] OP_STOP = 2'h2;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_CFGERR = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_WAITING = 3;
  localparam int ST_ENABLE_LSB = 8;
  localparam int ST_ERRDET_LSB = 16;

  // ----------------------------------------------------------------
  // Device write port: register selects and mode word layout
  // ----------------------------------------------------------------
  localparam logic [1:0] DEV_SEL_MODE = 2'h0;
  localparam logic [1:0] DEV_SEL_START = 2'h1;
  localparam logic [1:0] DEV_SEL_STOP = 2'h2;
  localparam int MODE_CKS_LSB = 14;
  localparam int MODE_CCS_BIT = 12;
  localparam int MODE_MASTER_BIT = 11;
  // Clock-select codes with this bit set pick the third or fourth prescaler output
  localparam int CKS_HIGH_OUT_BIT = 0;

  // ----------------------------------------------------------------
  // Settling wait after a pin-input mode write, in operating clocks
  // ----------------------------------------------------------------
  localparam logic [2:0] WAIT_FILTER_ON = 3'h4;
  localparam logic [2:0] WAIT_FILTER_OFF = 3'h2;

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_WRITE, S_DROP} host_state_t;

  // Nearest master below channel n; channel 0 is always a master
  function automatic logic [2:0] owner_of(input logic [7:0] masters, input int n);
    logic [2:0] own;
    own = 3'h0;
    for (int m = 1; m < 8; m++) begin
      if (m < n && masters[m]) begin
        own = m[2:0];
      end
    end
    return own;
  endfunction : owner_of

endpackage : timer_link_pkg

// File: verilog/link_check_if.sv
// Signals between the host controller and its linkage checker
`timescale 1ns/10ps
interface link_check_if;
  logic [7:0] masters;
  logic [7:0] slaves;
  logic [7:0] reqMask;
  logic [15:0] clkSel;
  logic [3:0] cfgErr;
  logic startBad;
  logic stopBad;

  modport judge (input masters, slaves, reqMask, clkSel, output cfgErr, startBad, stopBad);
  modport user (output masters, slaves, reqMask, clkSel, input cfgErr, startBad, stopBad);
endinterface : link_check_if

// File: verilog/link_checker.sv
// Combinational check of channel grouping and of start/stop masks
`timescale 1ns/10ps
module link_checker
  import timer_link_pkg::*;
(
  link_check_if.judge lc
);

  logic [7:0] effMasters;
  logic [7:0] oddMaster;
  logic [7:0] badSlave;
  logic [7:0] cksMis;
  logic [7:0] ckHigh;
  logic [7:0] linked;
  logic [7:0] groupAll;
  logic [7:0] partialStart;
  logic [7:0] partialStop;
  logic [7:0][7:0] slaveOf;

  assign effMasters = lc.masters | 8'h01;

  // ----------------------------------------------------------------
  // Per-channel grouping
  // ----------------------------------------------------------------
  genvar g, k;
  generate
    for (k = 0; k < 8; k++) begin : g_chan
      logic [2:0] own;
      assign own = owner_of(effMasters, k);
      assign oddMaster[k] = lc.masters[k] && (k % 2 == 1);
      assign badSlave[k] = lc.slaves[k] && (k == 0 || lc.masters[k]);
      for (g = 0; g < 8; g++) begin : g_own
        assign slaveOf[g][k] = lc.slaves[k] && (k != 0) && (own == g);
      end
      assign cksMis[k] = lc.slaves[k] && (lc.clkSel[2*k +: 2] != lc.clkSel[2*own +: 2]);
      assign linked[k] = |slaveOf[k];
      assign ckHigh[k] = (lc.slaves[k] || linked[k]) && lc.clkSel[2*k + CKS_HIGH_OUT_BIT];
      assign groupAll[k] = lc.reqMask[k] && ((slaveOf[k] & ~lc.reqMask) == 8'h00);
      assign partialStart[k] = lc.slaves[k] && lc.reqMask[k] && !groupAll[own];
      assign partialStop[k] = lc.slaves[k] && (lc.reqMask[k] != lc.reqMask[own]);
    end
  endgenerate

  assign lc.cfgErr = {|ckHigh, |cksMis, |badSlave, |oddMaster};
  assign lc.startBad = |partialStart;
  assign lc.stopBad = |partialStop;

endmodule : link_checker

// File: verification/timer_dev_model.sv
// Behavioural timer unit answering the host's four-phase write port
`timescale 1ns/10ps
module timer_dev_model
  import timer_link_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic devWrite,
  input wire logic [1:0] devRegSel,
  input wire logic [2:0] devChan,
  input wire logic [15:0] devWdata,
  input wire logic [7:0] chanInputPin,
  input wire logic [7:0] filterOn,
  output logic devAck,
  output logic [7:0] channelEnableStatus
);
  logic [15:0] modeReg [8];
  logic [15:0] lastStart;
  logic upperBad;
  logic [3:0] waitCnt;
  int cycle;
  int modeAckAt;
  int startAt;
  logic [1:0] divCnt;
  logic opTick;
  logic [7:0] pinS1, pinS2, pinS3, pinAcc, pinAccNext, pinPulse;
  logic [7:0] isMaster, ownClk, srcClk, srcClkDly;
  int chanCount [8];
  int pulseAt;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      devAck <= 1'b0;
      channelEnableStatus <= 8'h00;
      lastStart <= 16'h0000;
      upperBad <= 1'b0;
      waitCnt <= 4'h0;
      cycle <= 0;
      modeAckAt <= 0;
      startAt <= 0;
      for (int i = 0; i < 8; i++) begin
        modeReg[i] <= 16'h0000;
      end
    end else begin
      cycle <= cycle + 1;
      if (!devWrite) begin
        devAck <= 1'b0;
        waitCnt <= 4'h0;
      end else if (!devAck && waitCnt < (slow ? 4'h6 : 4'h0)) begin
        waitCnt <= waitCnt + 4'h1;
      end else if (!devAck) begin
        devAck <= 1'b1;
        case (devRegSel)
          DEV_SEL_MODE: begin
            modeReg[devChan] <= devWdata;
            if (devWdata[MODE_CCS_BIT]) begin
              modeAckAt <= cycle;
            end
          end
          DEV_SEL_START: begin
            channelEnableStatus <= channelEnableStatus | devWdata[7:0];
            lastStart <= devWdata;
            startAt <= cycle;
            upperBad <= upperBad | (|devWdata[15:8]);
          end
          DEV_SEL_STOP: begin
            channelEnableStatus <= channelEnableStatus & ~devWdata[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Count clocks and channel counters
  // ----------------------------------------------------------------
  // prescaled clock one-cycle pulse
  assign opTick = divCnt == 2'h3;

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      isMaster[c] = (c == 0) || modeReg[c][MODE_MASTER_BIT];
      pinAccNext[c] = filterOn[c] ? ((pinS2[c] == pinS3[c]) ? pinS3[c] : pinAcc[c]) : pinS1[c];
      ownClk[c] = modeReg[c][MODE_CCS_BIT] ? pinPulse[c] : opTick;
    end
    for (int c = 0; c < 8; c++) begin
      srcClk[c] = isMaster[c] ? ownClk[c] : ownClk[owner_of(isMaster, c)];
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt <= 2'h0;
      pinS1 <= 8'h00;
      pinS2 <= 8'h00;
      pinS3 <= 8'h00;
      pinAcc <= 8'h00;
      pinPulse <= 8'h00;
      srcClkDly <= 8'h00;
      pulseAt <= 0;
      for (int c = 0; c < 8; c++) begin
        chanCount[c] <= 0;
      end
    end else begin
      divCnt <= divCnt + 2'h1;
      pinPulse <= opTick ? (pinAccNext & ~pinAcc) : 8'h00;
      if (opTick) begin
        pinS1 <= chanInputPin;
        pinS2 <= pinS1;
        pinS3 <= pinS2;
        pinAcc <= pinAccNext;
      end
      if (opTick && |(pinAccNext & ~pinAcc)) begin
        pulseAt <= cycle;
      end
      srcClkDly <= srcClk;
      for (int c = 0; c < 8; c++) begin
        if (srcClkDly[c] && channelEnableStatus[c]) begin
          chanCount[c] <= chanCount[c] + 1;
        end
      end
    end
  end
endmodule : timer_dev_model

// File: verification/tb_timer_link_host.sv
// Self-checking bench for the timer link host controller
`timescale 1ns/10ps
module tb_timer_link_host
  import timer_link_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [3:0] sel = 4'h0;
  logic ack;
  logic devWrite;
  logic devAck;
  logic [31:0] datO;
  logic [1:0] devRegSel;
  logic [2:0] devChan;
  logic [15:0] devWdata;
  logic [7:0] enStat;
  logic [7:0] cfgM [4] = '{8'h03, 8'h01, 8'h05, 8'h05};
  logic [7:0] cfgS [4] = '{8'h00, 8'h01, 8'h0a, 8'h0a};
  logic [15:0] cfgC [4] = '{16'h0000, 16'h0000, 16'h0080, 16'h0005};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] pin = 8'h00;
  int base2, base3, riseAt;

  timer_link_host dut (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(datO), .devWrite(devWrite),
    .devRegSel(devRegSel), .devChan(devChan), .devWdata(devWdata), .devAck(devAck),
    .channelEnableStatus(enStat));
  timer_dev_model dev (.clock(clock), .sys_rst(sys_rst), .slow(slow), .devWrite(devWrite),
    .devRegSel(devRegSel), .devChan(devChan), .devWdata(devWdata), .chanInputPin(pin), .filterOn(8'h04), .devAck(devAck),
    .channelEnableStatus(enStat));

  initial begin
    forever #50 clock = ~clock;
  end

  task automatic end_sim;
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= {24'h000000, a};
    wdat <= d;
    we <= w;
    sel <= 4'hf;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1);
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("acklat", n, 32'h2);
  endtask : xfer

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string name);
    xfer(a, 1'b0, 32'h0);
    chk(name, rdat & m, e);
  endtask : rdc

  task automatic cmd(input logic [1:0] op, input logic [7:0] mask);
    slow <= ~slow;
    xfer(ADDR_CMD, 1'b1, {22'h0, op, mask});
    do begin
      xfer(ADDR_STATUS, 1'b0, 32'h0);
    end while (rdat[ST_BUSY] !== 1'b0);
  endtask : cmd

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(ADDR_MASTERS, 32'hff, 32'h01, "masters");
    rdc(ADDR_SLAVES, 32'hff, 32'h00, "slaves");
    rdc(ADDR_WAITSCALE, 32'hff, 32'h01, "waitscale");
    xfer(8'h20, 1'b1, 32'hff);
    rdc(8'h20, 32'hffffffff, 32'h0, "unmapped");
    xfer(ADDR_MASTERS, 1'b1, 32'h05);
    xfer(ADDR_SLAVES, 1'b1, 32'h0a);
    cmd(OP_START, 8'h0f);
    chk("startword", {16'h0, dev.lastStart}, 32'h000f);
    rdc(ADDR_STATUS, 32'hff06, 32'h0f00, "enable");
    for (int i = 0; i < 3; i++) begin
      xfer(ADDR_STATUS, 1'b1, 32'h4);
      cmd((i == 0) ? OP_START : ((i == 1) ? OP_STOP : 2'h3), (i == 1) ? 8'h01 : 8'h02);
      rdc(ADDR_STATUS, 32'hff04, 32'h0f04, "refusal");
    end
    xfer(ADDR_STATUS, 1'b1, 32'h4);
    cmd(OP_STOP, 8'h0f);
    cmd(OP_START, 8'h04);
    rdc(ADDR_STATUS, 32'hff04, 32'h0400, "masteronly");
    cmd(OP_STOP, 8'h0c);
    for (int i = 0; i < 4; i++) begin
      xfer(ADDR_MASTERS, 1'b1, {24'h0, cfgM[i]});
      xfer(ADDR_SLAVES, 1'b1, {24'h0, cfgS[i]});
      xfer(ADDR_CLKSEL, 1'b1, {16'h0, cfgC[i]});
      xfer(ADDR_STATUS, 1'b1, 32'h4);
      cmd(OP_START, 8'h01);
      rdc(ADDR_STATUS, 32'hfff06, {12'h0, 4'h1 << i, 16'h0006}, "cfgerr");
    end
    xfer(ADDR_STATUS, 1'b1, 32'h4);
    xfer(ADDR_CLKSEL, 1'b1, 32'h00a0);
    xfer(ADDR_PINSRC, 1'b1, 32'h04);
    xfer(ADDR_FILTER, 1'b1, 32'h04);
    xfer(ADDR_WAITSCALE, 1'b1, 32'h04);
    // Channel order 0, 1, 3, 2 so the start follows the pin mode write
    for (int c = 0; c < 4; c++) begin
      cmd(OP_MODE, 8'(c ^ (c >> 1)));
      chk("modeword", {16'h0, dev.modeReg[c ^ (c >> 1)]} & 32'hd800,
        {16'h0, (c > 1) ? 2'h2 : 2'h0, 1'b0, c == 3, c == 3, 11'h0});
    end
    cmd(OP_START, 8'h0c);
    chk("settle", {31'h0, (dev.startAt - dev.modeAckAt) >= 16}, 32'h1);
    chk("upper", {31'h0, dev.upperBad}, 32'h0);
    base2 = dev.chanCount[2];
    base3 = dev.chanCount[3];
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      pin[2] <= 1'b1;
      riseAt = dev.cycle;
      repeat (24) @(posedge clock);
      chk("lag", {31'h0, (dev.pulseAt - riseAt) inside {[12:16]}}, 32'h1);
      pin[2] <= 1'b0;
      repeat (24) @(posedge clock);
    end
    chk("mastercount", dev.chanCount[2] - base2, 32'h2);
    chk("slavecount", dev.chanCount[3] - base3, 32'h2);
    rdc(ADDR_STATUS, 32'hfff06, 32'h0c00, "final");
    end_sim();
  end
endmodule : tb_timer_link_host
